//--- core/ppmk_port_core.sv
/*
 * Port A key edge flags, port B and port C data and direction registers
 * with routing of pins to timer capture, timer compare and PWM channels.
 * Assumes the core drives one-cycle read and write strobes synchronous to
 * sys_clk and that pin inputs are already synchronous to sys_clk.
 */
// The implementer's own choice: the strobed register port.
`timescale 1ns/100ps
`include "ppmk_map.svh"

module ppmk_port_core #(
	parameter int PA_WIDTH = 8,
	parameter int PB_WIDTH = 5,
	parameter int PC_WIDTH = 7
) (
	input  wire logic                 sys_clk,
	input  wire logic                 reset,
	input  wire ppmk_pkg::ppmk_addr_t reg_addr,
	input  wire ppmk_pkg::ppmk_byte_t reg_wdata,
	input  wire logic                 reg_wr,
	input  wire logic                 reg_rd,
	output logic [7:0]                reg_rdata,
	input  wire logic                 irq_mask,
	input  wire logic [PA_WIDTH-1:0]  pa_in,
	output logic [PA_WIDTH-1:0]       pa_out,
	output logic [PA_WIDTH-1:0]       pa_oe,
	input  wire logic [PB_WIDTH-1:0]  pb_in,
	output logic [PB_WIDTH-1:0]       pb_out,
	output logic [PB_WIDTH-1:0]       pb_oe,
	input  wire logic [PC_WIDTH-1:0]  pc_in,
	output logic [PC_WIDTH-1:0]       pc_out,
	output logic [PC_WIDTH-1:0]       pc_oe,
	input  wire logic                 compare_one,
	input  wire logic                 compare_two,
	input  wire logic                 pwm_signal,
	output logic                      capture_channel_one,
	output logic                      capture_two,
	output logic                      key_irq,
	output logic                      low_ref_external,
	output logic                      high_ref_external,
	output logic                      amp_enable,
	output logic                      amp_to_channel_four
);

	// Widths are fixed by the field layout of the registers
	if (PA_WIDTH != 8 || PB_WIDTH != 5 || PC_WIDTH != 7) begin : g_bad_width
		$error("ppmk_port_core: port widths must be 8, 5 and 7");
	end

	typedef struct packed {
		logic [PA_WIDTH-1:0] pa_data;
		logic [PA_WIDTH-1:0] pa_dir;
		logic [7:0]          pa_cfg;
		logic [7:0]          flags;
		logic [PB_WIDTH-1:0] pb_data;
		logic [PB_WIDTH-1:0] pb_dir;
		logic [7:0]          route_cfg;
		logic [PC_WIDTH-1:0] pc_data;
		logic [PC_WIDTH-1:0] pc_dir;
		logic [6:0]          c_route;
		logic [PA_WIDTH-1:0] sync_a;
		logic [PA_WIDTH-1:0] sync_b;
		logic [PA_WIDTH-1:0] prev;
		logic [7:0]          rdata;
		logic [PA_WIDTH-1:0] pa_out;
		logic [PA_WIDTH-1:0] pa_oe;
		logic [PB_WIDTH-1:0] pb_out;
		logic [PB_WIDTH-1:0] pb_oe;
		logic [PC_WIDTH-1:0] pc_out;
		logic [PC_WIDTH-1:0] pc_oe;
		logic                cap1;
		logic                cap2;
		logic                irq;
		logic                lref;
		logic                href;
		logic                amp;
	} ppmk_state_t;

	ppmk_state_t st;
	ppmk_state_t next_st;
	logic [7:0]  set_ev;

	// Pin level on read for input lines, latch for output lines
	function automatic logic [7:0] ppmk_readback(input logic [7:0] dir,
		input logic [7:0] latch, input logic [7:0] pin);
		ppmk_readback = (dir & latch) | (~dir & pin);
	endfunction

	// Port C pins driven by compare channel one for a timer select code
	function automatic logic [6:0] ppmk_cmp1_mask(input logic [2:0] ts);
		case (ts)
			3'h2, 3'h3: ppmk_cmp1_mask = 7'h01;
			3'h4, 3'h5: ppmk_cmp1_mask = 7'h02;
			3'h6:       ppmk_cmp1_mask = 7'h10;
			3'h7:       ppmk_cmp1_mask = 7'h20;
			default:    ppmk_cmp1_mask = 7'h00;
		endcase
	endfunction

	// Qualified edge events per key line
	// edge polarity select
	genvar gi;
	generate
		for (gi = 0; gi < PA_WIDTH; gi++) begin : g_edge
			localparam bit HIGH_GROUP = (gi >= PA_WIDTH / 2);
			logic rising;
			logic enable;
			assign rising = HIGH_GROUP ? st.pa_cfg[`PPMK_HIGH_EDGE] :
				st.pa_cfg[`PPMK_LOW_EDGE];
			assign enable = HIGH_GROUP ? st.pa_cfg[`PPMK_HIGH_IE] :
				st.pa_cfg[`PPMK_LOW_IE];
			assign set_ev[gi] = enable && (rising ? (st.sync_b[gi] && !st.prev[gi]) :
				(!st.sync_b[gi] && st.prev[gi]));
		end
	endgenerate

	// Next state: register writes, reads, flags and pin routing
	always_comb begin
		logic [6:0] cmp_mask;
		logic [6:0] pwm_mask;
		logic [6:0] c_val;
		logic       cap_base;
		logic       cap_c4;
		logic [2:0] ts;
		logic [7:0] pb_rb;
		next_st = st;
		c_val = 7'h00;
		cap_base = 1'b0;
		ts = st.c_route[`PPMK_C_TS_HI:`PPMK_C_TS_LO];
		cmp_mask = ppmk_cmp1_mask(ts);
		pwm_mask = 7'h00;
		cap_c4 = ts[0] | (ts[2] & ts[1]);
		pb_rb = ppmk_readback({3'b000, st.pb_dir}, {3'b000, st.pb_data}, {3'b000, pb_in});
		case (st.c_route[`PPMK_C_PWM_HI:`PPMK_C_PWM_LO])
			2'h1:    pwm_mask = 7'h01;
			2'h2:    pwm_mask = 7'h10;
			2'h3:    pwm_mask = 7'h20;
			default: pwm_mask = 7'h00;
		endcase
		pwm_mask[6] = st.c_route[`PPMK_C6_PWM];

		// Input synchroniser and edge history
		next_st.sync_a = pa_in;
		next_st.sync_b = st.sync_a;
		next_st.prev = st.sync_b;

		// Register writes
		if (reg_wr) begin
			case (reg_addr)
				`PPMK_PA_DATA:   next_st.pa_data = reg_wdata[PA_WIDTH-1:0];
				`PPMK_PA_DIR:    next_st.pa_dir = reg_wdata[PA_WIDTH-1:0];
				`PPMK_PB_DATA:   next_st.pb_data = reg_wdata[PB_WIDTH-1:0];
				`PPMK_PB_DIR:    next_st.pb_dir = reg_wdata[PB_WIDTH-1:0];
				`PPMK_PC_DATA:   next_st.pc_data = reg_wdata[PC_WIDTH-1:0];
				`PPMK_PC_DIR:    next_st.pc_dir = reg_wdata[PC_WIDTH-1:0];
				`PPMK_PA_CFG:    next_st.pa_cfg = reg_wdata;
				`PPMK_ROUTE_CFG: next_st.route_cfg = reg_wdata;
				`PPMK_C_ROUTE:   next_st.c_route = reg_wdata[6:0];
				default:         next_st.pa_cfg = st.pa_cfg;
			endcase
		end

		if (reg_wr && reg_addr == `PPMK_KEY_FLAGS) begin
			next_st.flags = st.flags & ~reg_wdata;
		end
		next_st.flags = next_st.flags | set_ev;

		// Read data stands one cycle after the strobe only
		next_st.rdata = 8'h00;
		if (reg_rd) begin
			case (reg_addr)
				`PPMK_PA_DATA:   next_st.rdata = ppmk_readback(st.pa_dir, st.pa_data, pa_in);
				`PPMK_PA_DIR:    next_st.rdata = st.pa_dir;
				`PPMK_PB_DATA:   next_st.rdata = {2'b00, st.cap1, pb_rb[PB_WIDTH-1:0]};
				`PPMK_PB_DIR:    next_st.rdata = {3'b000, st.pb_dir};
				`PPMK_PC_DATA:   next_st.rdata = ppmk_readback({1'b0, st.pc_dir},
					{1'b0, st.pc_data}, {1'b0, pc_in});
				`PPMK_PC_DIR:    next_st.rdata = {1'b0, st.pc_dir};
				`PPMK_PA_CFG:    next_st.rdata = st.pa_cfg;
				`PPMK_ROUTE_CFG: next_st.rdata = st.route_cfg;
				`PPMK_KEY_FLAGS: next_st.rdata = st.flags;
				`PPMK_C_ROUTE:   next_st.rdata = {1'b0, st.c_route};
				default:         next_st.rdata = 8'h00;
			endcase
		end

		next_st.irq = (|st.flags) && !irq_mask;

		next_st.lref = st.pa_cfg[`PPMK_LOW_REF];
		next_st.href = st.pa_cfg[`PPMK_HIGH_REF];
		// line four direction is software's duty
		next_st.amp = st.route_cfg[`PPMK_AMP_EN];

		// Port A plain data and direction
		next_st.pa_out = st.pa_data;
		next_st.pa_oe = st.pa_dir;

		next_st.pb_out = st.pb_data;
		next_st.pb_oe = st.pb_dir;
		if (st.route_cfg[`PPMK_B1_CMP]) begin
			next_st.pb_out[1] = compare_one;
		end
		if (st.route_cfg[`PPMK_B3_CMP]) begin
			next_st.pb_out[3] = compare_two;
		end
		if (st.route_cfg[`PPMK_B4_PWM]) begin
			next_st.pb_out[4] = pwm_signal;
		end

		cap_base = st.route_cfg[`PPMK_B0_CAP] ? pb_in[0] : (cap_c4 ? pc_in[4] : pc_in[0]);
		next_st.cap1 = st.route_cfg[`PPMK_CAP_XOR] ? (cap_base ^ pb_in[2]) : cap_base;
		next_st.cap2 = st.route_cfg[`PPMK_B2_CAP] ? pb_in[2] : pc_in[2];

		// port C timer and PWM routing, compare before PWM except C5
		c_val = st.pc_data;
		c_val = (c_val & ~pwm_mask) | ({7{pwm_signal}} & pwm_mask);
		c_val = (c_val & ~cmp_mask) | ({7{compare_one}} & cmp_mask);
		if (pwm_mask[5]) begin
			c_val[5] = pwm_signal;
		end
		if (st.c_route[`PPMK_C3_CMP]) begin
			c_val[3] = compare_two;
		end
		next_st.pc_out = c_val;
		next_st.pc_oe = st.pc_dir;
		// low side lines only pull low
		next_st.pc_out[6:5] = 2'b00;
		next_st.pc_oe[6:5] = st.pc_dir[6:5] & c_val[6:5];
	end

	// State register; data latches keep their value through reset
	// directions cleared, data kept
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			st.pa_dir <= `PPMK_DIR_RESET;
			st.pa_cfg <= `PPMK_CFG_RESET;
			st.flags <= `PPMK_FLAG_RESET;
			st.pb_dir <= PB_WIDTH'(`PPMK_DIR_RESET);
			st.route_cfg <= `PPMK_CFG_RESET;
			st.pc_dir <= PC_WIDTH'(`PPMK_DIR_RESET);
			st.c_route <= 7'(`PPMK_CFG_RESET);
			// Edge history starts at the pulled-up idle level: no false edge
			st.sync_a <= '1;
			st.sync_b <= '1;
			st.prev <= '1;
			st.rdata <= 8'h00;
			st.pa_out <= '0;
			st.pa_oe <= '0;
			st.pb_out <= '0;
			st.pb_oe <= '0;
			st.pc_out <= '0;
			st.pc_oe <= '0;
			st.cap1 <= 1'b0;
			st.cap2 <= 1'b0;
			st.irq <= 1'b0;
			st.lref <= 1'b0;
			st.href <= 1'b0;
			st.amp <= 1'b0;
		end else begin
			st <= next_st;
		end
	end

	// Outputs straight from the state flip-flops
	assign reg_rdata = st.rdata;
	assign pa_out = st.pa_out;
	assign pa_oe = st.pa_oe;
	assign pb_out = st.pb_out;
	assign pb_oe = st.pb_oe;
	assign pc_out = st.pc_out;
	assign pc_oe = st.pc_oe;
	assign capture_channel_one = st.cap1;
	assign capture_two = st.cap2;
	assign key_irq = st.irq;
	assign low_ref_external = st.lref;
	assign high_ref_external = st.href;
	assign amp_enable = st.amp;
	assign amp_to_channel_four = st.amp;

	// Checks on flag, routing and read behaviour
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);

	a_low_rise_flag: assert property (
		(st.pa_cfg[`PPMK_LOW_IE] && st.pa_cfg[`PPMK_LOW_EDGE] && st.sync_b[0] && !st.prev[0])
		|=> st.flags[0]) else $error("rising edge on line 0 did not set flag");
	a_low_group_off: assert property (
		(!st.pa_cfg[`PPMK_LOW_IE] && st.flags[3:0] == 4'h0) |=> st.flags[3:0] == 4'h0)
		else $error("disabled low group set a flag");
	a_flag_one_clear: assert property (
		(reg_wr && reg_addr == `PPMK_KEY_FLAGS && reg_wdata[0] && !set_ev[0]
		&& st.flags[1] && !reg_wdata[1]) |=> (!st.flags[0] && st.flags[1]))
		else $error("flag clear did not act per bit");
	a_irq_follows_flags: assert property (
		((|st.flags) && !irq_mask) |=> key_irq) else $error("key request missing");
	a_pb_capture_read: assert property (
		(reg_rd && reg_addr == `PPMK_PB_DATA) |=> reg_rdata[`PPMK_CAP_READ_BIT] == $past(st.cap1))
		else $error("capture level not at bit five");
	a_pb_latch_read: assert property (
		(reg_rd && reg_addr == `PPMK_PB_DATA && st.pb_dir[3])
		|=> reg_rdata[3] == $past(st.pb_data[3])) else $error("output read not latch");
	a_b3_compare_out: assert property (
		(st.route_cfg[`PPMK_B3_CMP] && st.pb_dir[3])
		|=> (pb_oe[3] && pb_out[3] == $past(compare_two))) else $error("compare two not on B3");
	a_low_side_low: assert property (
		pc_out[6:5] == 2'b00) else $error("low side line driven high");
	a_amp_enable: assert property (
		st.route_cfg[`PPMK_AMP_EN] |=> (amp_enable && amp_to_channel_four))
		else $error("amplifier enable not followed");
	a_b1_compare_out: assert property (
		(st.route_cfg[`PPMK_B1_CMP] && st.pb_dir[1])
		|=> (pb_oe[1] && pb_out[1] == $past(compare_one))) else $error("compare one not on B1");
	a_b4_pwm_out: assert property (
		(st.route_cfg[`PPMK_B4_PWM] && st.pb_dir[4])
		|=> (pb_oe[4] && pb_out[4] == $past(pwm_signal))) else $error("PWM not on B4");
	a_cap_two_pin: assert property (
		st.route_cfg[`PPMK_B2_CAP] |=> capture_two == $past(pb_in[2]))
		else $error("capture two not from B2");
	a_cap_one_pin: assert property (
		(st.route_cfg[`PPMK_B0_CAP] && !st.route_cfg[`PPMK_CAP_XOR])
		|=> capture_channel_one == $past(pb_in[0])) else $error("capture one not from B0");
	a_irq_masked: assert property (
		irq_mask |=> !key_irq) else $error("masked key request raised");
	a_pc_dir_drive: assert property (
		1'b1 |=> pc_oe[4:0] == $past(st.pc_dir[4:0])) else $error("port C enable not direction");
	a_low_ref_follow: assert property (
		1'b1 |=> low_ref_external == $past(st.pa_cfg[`PPMK_LOW_REF]))
		else $error("low reference select not followed");

endmodule

//--- core/ppmk_map.svh
/*
 * Register indices, field positions and reset values of the port block.
 * Assumes it is included by bare name by the package user and the core.
 */
`ifndef PPMK_MAP_SVH
`define PPMK_MAP_SVH

// Register indices on the plain register port
`define PPMK_PA_DATA      6'h00
`define PPMK_PB_DATA      6'h01
`define PPMK_PC_DATA      6'h02
`define PPMK_PA_DIR       6'h04
`define PPMK_PB_DIR       6'h05
`define PPMK_PC_DIR       6'h06
`define PPMK_PA_CFG       6'h20
`define PPMK_ROUTE_CFG    6'h21
`define PPMK_KEY_FLAGS    6'h24
`define PPMK_C_ROUTE      6'h30

// Port A configuration fields
`define PPMK_LOW_REF      0
`define PPMK_LOW_IE       1
`define PPMK_LOW_EDGE     2
`define PPMK_HIGH_IE      4
`define PPMK_HIGH_EDGE    5
`define PPMK_HIGH_REF     7

// Pin routing configuration fields
`define PPMK_B0_CAP       0
`define PPMK_B1_CMP       1
`define PPMK_B2_CAP       2
`define PPMK_B3_CMP       3
`define PPMK_B4_PWM       4
`define PPMK_AMP_EN       6
`define PPMK_CAP_XOR      7

// Port C routing fields
`define PPMK_C_PWM_LO     0
`define PPMK_C_PWM_HI     1
`define PPMK_C3_CMP       2
`define PPMK_C_TS_LO      3
`define PPMK_C_TS_HI      5
`define PPMK_C6_PWM       6

// Bit of the port B data read that shows capture channel one
`define PPMK_CAP_READ_BIT 5

// Reset values
`define PPMK_CFG_RESET    8'h00
`define PPMK_DIR_RESET    8'h00
`define PPMK_FLAG_RESET   8'h00

`endif

//--- core/ppmk_pkg.sv
/*
 * Types shared by the port block.
 * Assumes the register map header is compiled alongside.
 */
package ppmk_pkg;

	typedef logic [7:0] ppmk_byte_t;
	typedef logic [5:0] ppmk_addr_t;

endpackage

//--- tb/ppmk_timer_model.sv
/*
 * Timer and PWM stand-in on the routed side of the port block.
 * Assumes the bench sets the wanted levels and that levels only change
 * on a rising edge of sys_clk.
 */
`timescale 1ns/100ps

module ppmk_timer_model (
	input  wire logic       sys_clk,
	input  wire logic       reset,
	input  wire logic [2:0] levels,
	output logic            compare_one,
	output logic            compare_two,
	output logic            pwm_signal
);
	// Outputs stay steady between bench commands, like a timer between matches
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			{pwm_signal, compare_two, compare_one} <= 3'h0;
		end else begin
			{pwm_signal, compare_two, compare_one} <= levels;
		end
	end
endmodule

//--- tb/test_port_pin_mux_and_key_irq.sv
/*
 * Self-checking bench for the port block: registers, key flags, routing.
 * Assumes the design core header and package are compiled first.
 */
`timescale 1ns/100ps
`include "ppmk_map.svh"
`define CHK(g, e) check(g, e)

module test_port_pin_mux_and_key_irq;
	typedef struct {logic [5:0] a; logic [7:0] w; logic [7:0] e;} ppmk_row_t;
	logic sys_clk, reset, reg_wr, reg_rd, irq_mask;
	ppmk_pkg::ppmk_addr_t reg_addr;
	ppmk_pkg::ppmk_byte_t reg_wdata;
	logic [7:0] reg_rdata, pa_in, pa_out, pa_oe;
	logic [4:0] pb_in, pb_out, pb_oe;
	logic [6:0] pc_in, pc_out, pc_oe;
	logic [2:0] levels;
	logic cmp1, cmp2, pwm, cap1, cap2, key_irq, lref, href, amp, amp4;
	int fail_count, total_checks;
	ppmk_row_t rows [11] = '{
		'{`PPMK_PB_DIR, 8'h1f, 8'h1f}, '{`PPMK_PB_DIR, 8'hff, 8'h1f},
		'{`PPMK_PC_DIR, 8'hff, 8'h7f}, '{`PPMK_PC_DIR, 8'h00, 8'h00},
		'{`PPMK_PB_DIR, 8'h00, 8'h00}, '{`PPMK_ROUTE_CFG, 8'h9f, 8'h9f},
		'{`PPMK_ROUTE_CFG, 8'h00, 8'h00}, '{`PPMK_PA_CFG, 8'ha5, 8'ha5},
		'{`PPMK_PA_CFG, 8'h00, 8'h00}, '{6'h3f, 8'hff, 8'h00},
		'{`PPMK_KEY_FLAGS, 8'h00, 8'h00}};

	ppmk_port_core i_dut (.sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.irq_mask(irq_mask), .pa_in(pa_in), .pa_out(pa_out), .pa_oe(pa_oe),
		.pb_in(pb_in), .pb_out(pb_out), .pb_oe(pb_oe), .pc_in(pc_in), .pc_out(pc_out),
		.pc_oe(pc_oe), .compare_one(cmp1), .compare_two(cmp2), .pwm_signal(pwm),
		.capture_channel_one(cap1), .capture_two(cap2), .key_irq(key_irq),
		.low_ref_external(lref), .high_ref_external(href), .amp_enable(amp),
		.amp_to_channel_four(amp4));

	ppmk_timer_model i_timer (.sys_clk(sys_clk), .reset(reset), .levels(levels),
		.compare_one(cmp1), .compare_two(cmp2), .pwm_signal(pwm));

	// Clock at 200 MHz
	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end

	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask

	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask

	// Read data stand only in the cycle after the read edge
	task automatic rd(input logic [5:0] a, input logic [7:0] e);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1;
		`CHK(reg_rdata, e);
	endtask

	task automatic pins(input logic [7:0] a, input logic [4:0] b, input int n);
		@(posedge sys_clk);
		pa_in <= a;
		pb_in <= b;
		cyc(n);
	endtask

	task automatic summarize;
		$display("comparisons %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// Watchdog well beyond the expected run
	initial begin
		#100000;
		fail_count++;
		summarize();
	end

	// Main sequence
	initial begin
		{reg_wr, reg_rd, irq_mask, reg_addr, reg_wdata} = '0;
		{pa_in, pb_in, pc_in, levels} = {8'hff, 5'h15, 7'h05, 3'h0};
		reset = 1'b1;
		repeat (2) @(posedge sys_clk);
		reset <= 1'b0;
		foreach (rows[i]) rd(rows[i].a, 8'h00);
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].w);
			rd(rows[i].a, rows[i].e);
		end
		$display("test registers done");
		wr(`PPMK_PA_CFG, 8'h02);
		pins(8'hfe, 5'h15, 6);
		rd(`PPMK_KEY_FLAGS, 8'h01);
		`CHK(key_irq, 8'h01);
		pins(8'hff, 5'h15, 6);
		rd(`PPMK_KEY_FLAGS, 8'h01);
		@(posedge sys_clk);
		irq_mask <= 1'b1;
		cyc(3);
		`CHK(key_irq, 8'h00);
		@(posedge sys_clk);
		irq_mask <= 1'b0;
		wr(`PPMK_KEY_FLAGS, 8'h00);
		rd(`PPMK_KEY_FLAGS, 8'h01);
		wr(`PPMK_KEY_FLAGS, 8'h01);
		rd(`PPMK_KEY_FLAGS, 8'h00);
		wr(`PPMK_PA_CFG, 8'h06);
		pins(8'hfc, 5'h15, 6);
		rd(`PPMK_KEY_FLAGS, 8'h00);
		pins(8'hff, 5'h15, 6);
		rd(`PPMK_KEY_FLAGS, 8'h03);
		wr(`PPMK_KEY_FLAGS, 8'h01);
		rd(`PPMK_KEY_FLAGS, 8'h02);
		wr(`PPMK_KEY_FLAGS, 8'h02);
		wr(`PPMK_PA_CFG, 8'h05);
		pins(8'hfb, 5'h15, 6);
		pins(8'hff, 5'h15, 6);
		rd(`PPMK_KEY_FLAGS, 8'h00);
		`CHK({href, lref}, 8'h01);
		wr(`PPMK_PA_CFG, 8'h90);
		pins(8'hef, 5'h15, 6);
		rd(`PPMK_KEY_FLAGS, 8'h10);
		`CHK({href, lref}, 8'h02);
		wr(`PPMK_KEY_FLAGS, 8'h10);
		pins(8'hff, 5'h15, 6);
		$display("test key flags done");
		wr(`PPMK_PB_DATA, 8'h0a);
		wr(`PPMK_PB_DIR, 8'h0f);
		cyc(3);
		`CHK(pb_oe, 8'h0f);
		`CHK(pb_out[3:0], 8'h0a);
		rd(`PPMK_PB_DATA, 8'h3a);
		@(posedge sys_clk);
		levels <= 3'b100;
		// software drives line four as output
		wr(`PPMK_PB_DIR, 8'h1f);
		wr(`PPMK_ROUTE_CFG, 8'h1a);
		cyc(4);
		`CHK(pb_out, 8'h10);
		@(posedge sys_clk);
		levels <= 3'b011;
		cyc(4);
		`CHK(pb_out, 8'h0a);
		wr(`PPMK_PB_DIR, 8'h00);
		wr(`PPMK_ROUTE_CFG, 8'h05);
		cyc(4);
		`CHK({cap1, cap2}, 8'h03);
		pins(8'hff, 5'h10, 6);
		`CHK({cap1, cap2}, 8'h00);
		wr(`PPMK_ROUTE_CFG, 8'h00);
		cyc(4);
		`CHK({cap1, cap2}, 8'h03);
		wr(`PPMK_ROUTE_CFG, 8'h81);
		pins(8'hff, 5'h05, 6);
		`CHK(cap1, 8'h00);
		pins(8'hff, 5'h01, 6);
		`CHK(cap1, 8'h01);
		wr(`PPMK_PA_DATA, 8'h5a);
		wr(`PPMK_PA_DIR, 8'hf0);
		cyc(3);
		`CHK(pa_oe, 8'hf0);
		`CHK(pa_out, 8'h5a);
		rd(`PPMK_PA_DATA, 8'h5f);
		// line four made an input before the amplifier is enabled
		wr(`PPMK_PA_DIR, 8'h00);
		wr(`PPMK_ROUTE_CFG, 8'h40);
		cyc(3);
		`CHK({amp, amp4}, 8'h03);
		wr(`PPMK_ROUTE_CFG, 8'h00);
		cyc(3);
		`CHK(amp, 8'h00);
		$display("test port b done");
		wr(`PPMK_PC_DATA, 8'h7f);
		wr(`PPMK_PC_DIR, 8'h7f);
		cyc(3);
		`CHK(pc_out, 8'h1f);
		`CHK(pc_oe, 8'h7f);
		wr(`PPMK_C_ROUTE, 8'h77);
		@(posedge sys_clk);
		levels <= 3'b001;
		cyc(4);
		`CHK(pc_out, 8'h17);
		`CHK(pc_oe, 8'h1f);
		`CHK({cap1, cap2}, 8'h01);
		@(posedge sys_clk);
		reset <= 1'b1;
		repeat (2) @(posedge sys_clk);
		reset <= 1'b0;
		#1;
		`CHK(pc_oe, 8'h00);
		`CHK({href, lref}, 8'h00);
		rd(`PPMK_PC_DIR, 8'h00);
		rd(`PPMK_PC_DATA, 8'h05);
		wr(`PPMK_PC_DIR, 8'h1f);
		cyc(3);
		`CHK(pc_out, 8'h1f);
		$display("test port c done");
		summarize();
	end
endmodule
